// *** asp_device.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_device #(
    parameter int STANDBY_N_PIN_CYC = asp_pkg::STANDBY_N_PIN_SETTLE_CYC,
    parameter int SHDN_CYC = asp_pkg::SHDN_SETTLE_CYC
) (
    input  wire logic                                              clk,
    input  wire logic                                              rst,
    asp_link_if.dev                                                link,
    input  wire logic [asp_pkg::NCH-1:0][asp_pkg::RES_W-1:0]       analog_code,
    output logic                                                   front_end_powered,
    output logic                                                   core_powered
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        asp_pkg::asp_pwr_e                              pwr;
        logic [asp_pkg::CNT_W-1:0]                      settle;
        logic                                           need_rst;
        logic                                           a_q;
        logic                                           b_q;
        logic                                           held_a;
        logic                                           held_b;
        logic                                           busy;
        logic [7:0]                                     conv;
        logic [asp_pkg::NCH-1:0][asp_pkg::RES_W-1:0]    hold;
        logic [asp_pkg::NCH-1:0][asp_pkg::RES_W-1:0]    res;
        logic [3:0]                                     idx;
        logic                                           strobe_q;
        logic [asp_pkg::RES_W-1:0]                      db;
        logic                                           db_en;
        logic                                           frst;
    } asp_dev_s;

    localparam logic [7:0]                 CONV_LAST = 8'(asp_pkg::CONV_CYC - 1);
    localparam logic [asp_pkg::CNT_W-1:0]  STANDBY_N_PIN_LAST = asp_pkg::CNT_W'(STANDBY_N_PIN_CYC - 1);
    localparam logic [asp_pkg::CNT_W-1:0]  SHDN_LAST = asp_pkg::CNT_W'(SHDN_CYC - 1);
    localparam logic [3:0]                 PAR_LAST  = 4'(asp_pkg::NCH - 1);
    localparam logic [3:0]                 BYTE_LAST = 4'(2 * asp_pkg::NCH - 1);

    asp_dev_s                      s_ff;
    asp_dev_s                      nxt_s;
    logic                          rise_a;
    logic                          rise_b;
    logic                          strobe_fall;
    logic                          ready;
    logic [1:0]                    mode;
    logic                          par_mode;
    logic                          byte_mode;
    logic [3:0]                    ch;
    logic [asp_pkg::RES_W-1:0]     word;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_s          = s_ff;
        nxt_s.a_q      = link.convert_start_group_a;
        nxt_s.b_q      = link.convert_start_group_b;
        nxt_s.strobe_q = link.cs_rd_n;
        rise_a         = link.convert_start_group_a & ~s_ff.a_q;
        rise_b         = link.convert_start_group_b & ~s_ff.b_q;
        strobe_fall    = s_ff.strobe_q & ~link.cs_rd_n;
        mode           = {link.interface_mode_select, link.serial_or_byte_select};
        par_mode       = (mode == asp_pkg::MODE_PAR);
        byte_mode      = (mode == asp_pkg::MODE_BYTE);
        ch             = par_mode ? s_ff.idx : {1'b0, s_ff.idx[3:1]};
        word           = s_ff.res[ch[2:0]];

        // power sequencing; entry is checked every cycle ahead of everything else
        if (!link.standby_n_pin) begin
            nxt_s.pwr    = link.range_pin ? asp_pkg::PWR_STANDBY_N_PIN : asp_pkg::PWR_SHDN;
            nxt_s.busy   = 1'b0;
            nxt_s.held_a = 1'b0;
            nxt_s.held_b = 1'b0;
            if (!link.range_pin) begin
                nxt_s.need_rst = 1'b1;
            end
        end else begin
            case (s_ff.pwr)
                asp_pkg::PWR_STANDBY_N_PIN: begin
                    nxt_s.pwr    = asp_pkg::PWR_SETTLE;
                    nxt_s.settle = STANDBY_N_PIN_LAST;
                end
                asp_pkg::PWR_SHDN: begin
                    nxt_s.pwr    = asp_pkg::PWR_SETTLE;
                    nxt_s.settle = SHDN_LAST;
                end
                asp_pkg::PWR_SETTLE: begin
                    if (s_ff.settle == '0) begin
                        nxt_s.pwr = asp_pkg::PWR_RUN;
                    end else begin
                        nxt_s.settle = s_ff.settle - 1'b1;
                    end
                end
                asp_pkg::PWR_RUN: begin
                    nxt_s.pwr = asp_pkg::PWR_RUN;
                end
                default: begin
                    nxt_s.pwr = asp_pkg::PWR_RUN;
                end
            endcase
        end

        // the reset pin aborts any pending sample and rewinds the readout
        if (link.reset_pin) begin
            // a shutdown entry in the same cycle keeps the reset demand
            nxt_s.need_rst = ~link.standby_n_pin & ~link.range_pin;
            nxt_s.busy     = 1'b0;
            nxt_s.held_a   = 1'b0;
            nxt_s.held_b   = 1'b0;
            nxt_s.idx      = '0;
        end

        // sampling: a shutdown that was not followed by a reset blocks new samples
        ready = (s_ff.pwr == asp_pkg::PWR_RUN) & ~s_ff.need_rst & link.standby_n_pin & ~link.reset_pin;
        if (ready && !s_ff.busy) begin
            if (rise_a && !s_ff.held_a) begin
                nxt_s.held_a          = 1'b1;
                nxt_s.hold[asp_pkg::GRP-1:0] = analog_code[asp_pkg::GRP-1:0];
            end
            if (rise_b && !s_ff.held_b) begin
                nxt_s.held_b          = 1'b1;
                nxt_s.hold[asp_pkg::NCH-1:asp_pkg::GRP] = analog_code[asp_pkg::NCH-1:asp_pkg::GRP];
            end
            if (nxt_s.held_a && nxt_s.held_b) begin
                nxt_s.busy   = 1'b1;
                nxt_s.conv   = CONV_LAST;
                nxt_s.held_a = 1'b0;
                nxt_s.held_b = 1'b0;
            end
        end

        // conversion on the internal time base; results land as busy drops
        if (s_ff.busy && nxt_s.busy) begin
            if (s_ff.conv == '0) begin
                nxt_s.busy = 1'b0;
                nxt_s.res  = s_ff.hold;
                nxt_s.idx  = '0;
            end else begin
                nxt_s.conv = s_ff.conv - 1'b1;
            end
        end

        // readout; serial mode leaves the bus released
        if (link.cs_rd_n) begin
            nxt_s.db_en = 1'b0;
        end else if (strobe_fall && (par_mode || byte_mode)) begin
            nxt_s.db_en = 1'b1;
            nxt_s.frst  = (ch == '0);
            if (par_mode) begin
                nxt_s.db  = word;
                nxt_s.idx = (s_ff.idx >= PAR_LAST) ? '0 : s_ff.idx + 1'b1;
            end else begin
                nxt_s.db  = {8'h00, s_ff.idx[0] ? word[7:0] : word[15:8]};
                nxt_s.idx = (s_ff.idx >= BYTE_LAST) ? '0 : s_ff.idx + 1'b1;
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign link.busy                     = s_ff.busy;
    assign link.parallel_result_bus_out  = s_ff.db;
    assign link.parallel_result_bus_oe_n = ~s_ff.db_en;
    assign link.first_channel_flag_out   = s_ff.frst;
    assign link.first_channel_flag_oe_n  = ~s_ff.db_en;
    assign front_end_powered = (s_ff.pwr != asp_pkg::PWR_STANDBY_N_PIN) && (s_ff.pwr != asp_pkg::PWR_SHDN);
    assign core_powered      = (s_ff.pwr != asp_pkg::PWR_SHDN);

endmodule : asp_device
`default_nettype wire

// *** asp_pkg.sv ***
package asp_pkg;
    // ****************************************
    // widths and timing
    // ****************************************
    localparam int CLK_HZ          = 50_000_000;
    localparam int NCH             = 6;
    localparam int GRP             = 3;
    localparam int RES_W           = 16;
    localparam int CNT_W           = 20;
    localparam int STANDBY_N_PIN_SETTLE_US  = 100;
    // scaled through kHz so the product stays inside a 32-bit int
    localparam int STANDBY_N_PIN_SETTLE_CYC = (STANDBY_N_PIN_SETTLE_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int SHDN_SETTLE_MS  = 13;
    localparam int SHDN_SETTLE_CYC = (SHDN_SETTLE_MS * CLK_HZ + 999) / 1000;
    // longest conversion; the device finishes inside it
    localparam int CONV_TIME_NS    = 3000;
    localparam int CONV_CYC        = CONV_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int START_PULSE_CYC = 2;
    localparam int RST_PULSE_CYC   = 2;

    // ****************************************
    // host register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CMD      = 8'h04;
    localparam logic [7:0] OFS_STAT     = 8'h08;
    localparam logic [7:0] OFS_RES0     = 8'h10;
    localparam int         CTRL_STANDBY_N_PIN_N  = 0;
    localparam int         CTRL_RANGE   = 1;
    localparam int         CTRL_SPLIT   = 2;
    localparam int         CTRL_RESET   = 3;
    localparam int         CMD_A        = 0;
    localparam int         CMD_B        = 1;
    localparam int         STAT_BUSY    = 0;
    localparam int         STAT_SETTLE  = 1;
    localparam int         STAT_NEEDRST = 2;
    localparam int         STAT_DONE    = 3;
    localparam int         STAT_IDLE    = 4;
    localparam logic [2:0] CTRL_RST_VAL = 3'h1;

    // ****************************************
    // pin encodings and states
    // ****************************************
    localparam logic [1:0] MODE_PAR  = 2'h0;
    localparam logic [1:0] MODE_BYTE = 2'h3;
    localparam logic [1:0] MODE_SER  = 2'h2;
    localparam logic [2:0] OS_NONE   = 3'h0;

    typedef enum logic [1:0] {PWR_RUN, PWR_STANDBY_N_PIN, PWR_SHDN, PWR_SETTLE} asp_pwr_e;
    typedef enum logic [1:0] {H_IDLE, H_RD_LO, H_RD_HI} asp_hst_e;
endpackage : asp_pkg

// *** asp_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface asp_link_if;
    logic                 standby_n_pin;
    logic                 range_pin;
    logic                 reset_pin;
    logic                 convert_start_group_a;
    logic                 convert_start_group_b;
    logic [2:0]           oversample_sel;
    logic                 interface_mode_select;
    logic                 serial_or_byte_select;
    logic                 cs_rd_n;
    logic                 busy;
    logic [15:0]          parallel_result_bus_out;
    logic                 parallel_result_bus_oe_n;
    logic                 first_channel_flag_out;
    logic                 first_channel_flag_oe_n;
    logic [15:0]          parallel_result_bus;
    logic                 first_channel_flag;

    // undriven bus modelled as pulled low
    assign parallel_result_bus = parallel_result_bus_oe_n ? 16'h0000 : parallel_result_bus_out;
    assign first_channel_flag  = first_channel_flag_oe_n ? 1'b0 : first_channel_flag_out;

    modport dev (
        input  standby_n_pin, range_pin, reset_pin, convert_start_group_a, convert_start_group_b,
        input  oversample_sel, interface_mode_select, serial_or_byte_select, cs_rd_n,
        output busy, parallel_result_bus_out, parallel_result_bus_oe_n,
        output first_channel_flag_out, first_channel_flag_oe_n
    );
    modport host (
        output standby_n_pin, range_pin, reset_pin, convert_start_group_a, convert_start_group_b,
        output oversample_sel, interface_mode_select, serial_or_byte_select, cs_rd_n,
        input  busy, parallel_result_bus, first_channel_flag
    );
endinterface : asp_link_if
`default_nettype wire

// *** asp_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_host #(
    parameter int STANDBY_N_PIN_CYC = asp_pkg::STANDBY_N_PIN_SETTLE_CYC,
    parameter int SHDN_CYC = asp_pkg::SHDN_SETTLE_CYC
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [31:0]   paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    asp_link_if.host           link
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0]                                     ctrl;
        logic [1:0]                                     rst_cnt;
        logic [1:0]                                     pa;
        logic [1:0]                                     pb;
        logic [asp_pkg::CNT_W-1:0]                      settle;
        logic                                           need_rst;
        logic                                           done;
        logic                                           busy_q;
        logic                                           cs_n;
        asp_pkg::asp_hst_e                              st;
        logic                                           ph;
        logic [2:0]                                     idx;
        logic [asp_pkg::NCH-1:0][asp_pkg::RES_W-1:0]    res;
        logic [31:0]                                    rdata;
    } asp_host_s;

    localparam logic [1:0]                 PULSE    = 2'(asp_pkg::START_PULSE_CYC);
    localparam logic [1:0]                 RPULSE   = 2'(asp_pkg::RST_PULSE_CYC);
    localparam logic [asp_pkg::CNT_W-1:0]  STANDBY_N_PIN_W   = asp_pkg::CNT_W'(STANDBY_N_PIN_CYC);
    localparam logic [asp_pkg::CNT_W-1:0]  SHDN_W   = asp_pkg::CNT_W'(SHDN_CYC);
    localparam logic [2:0]                 LAST_CH  = 3'(asp_pkg::NCH - 1);

    asp_host_s      s_ff;
    asp_host_s      nxt_s;
    logic           setup;
    logic           wr;
    logic [7:0]     ofs;
    logic           res_hit;
    logic [2:0]     res_idx;
    logic           mapped;
    logic           can_start;

    always_comb begin
        nxt_s     = s_ff;
        nxt_s.busy_q = link.busy;
        ofs       = paddr[7:0];
        res_idx   = 3'((ofs - asp_pkg::OFS_RES0) >> 2);
        res_hit   = (ofs >= asp_pkg::OFS_RES0) && (ofs[1:0] == 2'h0)
                  && (ofs < asp_pkg::OFS_RES0 + 8'(4 * asp_pkg::NCH));
        mapped    = res_hit || ofs == asp_pkg::OFS_CTRL || ofs == asp_pkg::OFS_CMD || ofs == asp_pkg::OFS_STAT;
        mapped    = mapped && (paddr[31:8] == '0);
        setup     = psel & ~penable;
        wr        = psel & penable & pwrite & mapped;
        can_start = (s_ff.st == asp_pkg::H_IDLE) & ~link.busy & ~s_ff.busy_q & (s_ff.settle == '0)
                  & ~s_ff.need_rst & s_ff.ctrl[asp_pkg::CTRL_STANDBY_N_PIN_N] & (s_ff.rst_cnt == '0);

        if (s_ff.settle != '0) nxt_s.settle = s_ff.settle - 1'b1;
        if (s_ff.rst_cnt != '0) nxt_s.rst_cnt = s_ff.rst_cnt - 1'b1;
        if (s_ff.pa != '0) nxt_s.pa = s_ff.pa - 1'b1;
        if (s_ff.pb != '0) nxt_s.pb = s_ff.pb - 1'b1;

        // ****************************************
        // register writes
        // ****************************************
        if (wr && ofs == asp_pkg::OFS_CTRL) begin
            nxt_s.ctrl = pwdata[2:0];
            // a reset in the same write as a wake from shutdown does not count
            if (pwdata[asp_pkg::CTRL_RESET]) begin
                nxt_s.rst_cnt  = RPULSE;
                nxt_s.need_rst = 1'b0;
            end
            if (!s_ff.ctrl[asp_pkg::CTRL_STANDBY_N_PIN_N] && pwdata[asp_pkg::CTRL_STANDBY_N_PIN_N]) begin
                if (s_ff.ctrl[asp_pkg::CTRL_RANGE]) begin
                    nxt_s.settle = STANDBY_N_PIN_W;
                end else begin
                    nxt_s.settle   = SHDN_W;
                    nxt_s.need_rst = 1'b1;
                end
            end
        end
        if (wr && ofs == asp_pkg::OFS_CMD && can_start) begin
            if (pwdata[asp_pkg::CMD_A] || !s_ff.ctrl[asp_pkg::CTRL_SPLIT]) nxt_s.pa = PULSE;
            if (pwdata[asp_pkg::CMD_B] && s_ff.ctrl[asp_pkg::CTRL_SPLIT]) nxt_s.pb = PULSE;
            nxt_s.done = 1'b0;
        end

        // ****************************************
        // readout after busy falls
        // ****************************************
        case (s_ff.st)
            asp_pkg::H_IDLE: begin
                if (s_ff.busy_q && !link.busy) begin
                    nxt_s.st   = asp_pkg::H_RD_LO;
                    nxt_s.cs_n = 1'b0;
                    nxt_s.idx  = '0;
                    nxt_s.ph   = 1'b0;
                end
            end
            asp_pkg::H_RD_LO: begin
                nxt_s.ph = 1'b1;
                if (s_ff.ph) begin
                    nxt_s.res[s_ff.idx] = link.parallel_result_bus;
                    nxt_s.cs_n          = 1'b1;
                    nxt_s.st            = asp_pkg::H_RD_HI;
                end
            end
            asp_pkg::H_RD_HI: begin
                nxt_s.ph = 1'b0;
                if (s_ff.idx == LAST_CH) begin
                    nxt_s.st   = asp_pkg::H_IDLE;
                    nxt_s.done = 1'b1;
                end else begin
                    nxt_s.idx  = s_ff.idx + 1'b1;
                    nxt_s.cs_n = 1'b0;
                    nxt_s.st   = asp_pkg::H_RD_LO;
                end
            end
            default: begin
                nxt_s.st   = asp_pkg::H_IDLE;
                nxt_s.cs_n = 1'b1;
            end
        endcase

        // read data is captured in the setup cycle so the access phase needs no wait
        if (setup) begin
            nxt_s.rdata = '0;
            if (res_hit) begin
                nxt_s.rdata = {16'h0000, s_ff.res[res_idx]};
            end else if (ofs == asp_pkg::OFS_CTRL) begin
                nxt_s.rdata = {29'h0, s_ff.ctrl};
            end else if (ofs == asp_pkg::OFS_STAT) begin
                nxt_s.rdata = {27'h0, s_ff.st == asp_pkg::H_IDLE, s_ff.done, s_ff.need_rst,
                               s_ff.settle != '0, link.busy};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff      <= '0;
            s_ff.ctrl <= asp_pkg::CTRL_RST_VAL;
            s_ff.cs_n <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign pready                     = 1'b1;
    assign pslverr                    = psel & penable & ~mapped;
    assign prdata                     = s_ff.rdata;
    assign link.standby_n_pin         = s_ff.ctrl[asp_pkg::CTRL_STANDBY_N_PIN_N];
    assign link.range_pin             = s_ff.ctrl[asp_pkg::CTRL_RANGE];
    assign link.reset_pin             = (s_ff.rst_cnt != '0);
    assign link.convert_start_group_a = (s_ff.pa != '0);
    // in common mode both inputs follow one signal
    assign link.convert_start_group_b = s_ff.ctrl[asp_pkg::CTRL_SPLIT] ? (s_ff.pb != '0) : (s_ff.pa != '0);
    assign link.oversample_sel        = asp_pkg::OS_NONE;
    assign link.interface_mode_select = asp_pkg::MODE_PAR[1];
    assign link.serial_or_byte_select = asp_pkg::MODE_PAR[0];
    assign link.cs_rd_n               = s_ff.cs_n;

endmodule : asp_host
`default_nettype wire

// *** asp_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic standby_n_pin,
    input wire logic convert_start_group_a,
    input wire logic convert_start_group_b,
    input wire logic cs_rd_n,
    input wire logic busy,
    input wire logic parallel_result_bus_oe_n,
    input wire logic first_channel_flag_out,
    input wire logic first_channel_flag_oe_n
);
    // ********
    // checks
    // ********
    logic [9:0] bcnt_ff;
    always_ff @(posedge clk) bcnt_ff <= (rst || !busy) ? 10'h000 : bcnt_ff + 10'h001;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // mode pins stay parallel, so each strobe fall is a read
    sequence s_rd; $fell(cs_rd_n); endsequence
    sequence s_first; $fell(busy) ##[1:3] s_rd; endsequence
    property p_pd; !standby_n_pin |=> !busy; endproperty
    a_pd: assert property (p_pd) else $error("busy in power-down");
    property p_cause; $rose(busy) |-> $past(convert_start_group_a || convert_start_group_b); endproperty
    a_cause: assert property (p_cause) else $error("busy without start");
    property p_max; bcnt_ff <= asp_pkg::CONV_CYC; endproperty
    a_max: assert property (p_max) else $error("busy too long");
    property p_hold; $rose(busy) ##1 standby_n_pin [*8] |-> busy; endproperty
    a_hold: assert property (p_hold) else $error("busy dropped early");
    property p_drive; s_rd |-> ##[1:2] !parallel_result_bus_oe_n; endproperty
    a_drive: assert property (p_drive) else $error("bus not driven");
    property p_rel; $rose(cs_rd_n) |-> ##[1:2] (parallel_result_bus_oe_n && first_channel_flag_oe_n); endproperty
    a_rel: assert property (p_rel) else $error("bus not released");
    property p_next; s_rd ##0 first_channel_flag_out |-> ##[1:2] !first_channel_flag_out; endproperty
    a_next: assert property (p_next) else $error("flag stays high");
    property p_first; s_first |-> ##[1:2] (first_channel_flag_out && !first_channel_flag_oe_n); endproperty
    a_first: assert property (p_first) else $error("flag missing");
endmodule : asp_sva
`default_nettype wire

// *** asp_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module asp_bench;
    logic             clk, rst, psel, penable, pwrite, pready, pslverr, err, fe, core;
    logic [31:0]      paddr, pwdata, prdata, rd;
    logic [5:0][15:0] ana, a0;
    int               bad_count, n_checks;
    asp_link_if lk ();
    asp_device #(.STANDBY_N_PIN_CYC(20), .SHDN_CYC(40)) i_asp_device (.clk(clk), .rst(rst), .link(lk), .analog_code(ana),
        .front_end_powered(fe), .core_powered(core));
    asp_host #(.STANDBY_N_PIN_CYC(20), .SHDN_CYC(40)) i_asp_host (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(lk));
    asp_sva i_asp_sva (.clk(clk), .rst(rst), .standby_n_pin(lk.standby_n_pin), .cs_rd_n(lk.cs_rd_n), .busy(lk.busy),
        .convert_start_group_a(lk.convert_start_group_a), .convert_start_group_b(lk.convert_start_group_b),
        .parallel_result_bus_oe_n(lk.parallel_result_bus_oe_n), .first_channel_flag_out(lk.first_channel_flag_out),
        .first_channel_flag_oe_n(lk.first_channel_flag_oe_n));
    // ********
    // tasks
    // ********
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string w);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", w, e, s);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        paddr <= {24'h000000, a};
        pwrite <= wr;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        do apb(1'b0, asp_pkg::OFS_STAT, 32'h0); while (rd[b] !== v && n++ < 400);
        chk(32'(rd[b]), 32'(v), "status");
    endtask : poll
    task automatic conv(input logic [1:0] c, input logic [5:0][15:0] e);
        apb(1'b1, asp_pkg::OFS_CMD, {30'h0, c});
        poll(asp_pkg::STAT_BUSY, 1'b1);
        poll(asp_pkg::STAT_DONE, 1'b1);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, asp_pkg::OFS_RES0 + 8'(4 * i), 32'h0);
            chk(rd, {16'h0000, e[i]}, "result");
        end
    endtask : conv
    // start is refused, so busy must stay low
    task automatic nostart(input logic f, input logic k);
        apb(1'b1, asp_pkg::OFS_CMD, 32'h0000_0003);
        repeat (8) @(posedge clk);
        apb(1'b0, asp_pkg::OFS_STAT, 32'h0);
        chk(32'(rd[0]), 32'h0, "busy");
        chk({30'h0, fe, core}, {30'h0, f, k}, "power");
    endtask : nostart
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400_000;
        bad_count++;
        wrap_up();
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 64'h0};
        a0 = {16'h6006, 16'h5005, 16'h4004, 16'h3003, 16'h2002, 16'h1001};
        ana = a0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, asp_pkg::OFS_CTRL, 32'h0);
        chk(rd, {29'h0, asp_pkg::CTRL_RST_VAL}, "ctrl");
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[31:1], err}, 32'h1, "unmapped");
        conv(2'h3, a0);
        apb(1'b1, asp_pkg::OFS_CTRL, 32'h5);
        apb(1'b1, asp_pkg::OFS_CMD, 32'h1);
        repeat (4) @(posedge clk);
        ana <= ~a0;
        repeat (4) @(posedge clk);
        apb(1'b0, asp_pkg::OFS_STAT, 32'h0);
        chk(32'(rd[0]), 32'h0, "busy");
        conv(2'h2, {~a0[5:3], a0[2:0]});
        apb(1'b1, asp_pkg::OFS_CTRL, 32'h2);
        nostart(1'b0, 1'b1);
        apb(1'b1, asp_pkg::OFS_CTRL, 32'h1);
        poll(asp_pkg::STAT_SETTLE, 1'b0);
        conv(2'h3, ~a0);
        apb(1'b1, asp_pkg::OFS_CTRL, 32'h0);
        nostart(1'b0, 1'b0);
        apb(1'b1, asp_pkg::OFS_CTRL, 32'h1);
        poll(asp_pkg::STAT_SETTLE, 1'b0);
        nostart(1'b1, 1'b1);
        chk(32'(rd[asp_pkg::STAT_NEEDRST]), 32'h1, "reset needed");
        ana <= a0;
        apb(1'b1, asp_pkg::OFS_CTRL, 32'h9);
        conv(2'h3, a0);
        wrap_up();
    end
endmodule : asp_bench
`default_nettype wire
